// file: hw/ldpr_column_cell.sv
// One column source: compares the free running phase with the dot level.
`timescale 1ns/1ps
module ldpr_column_cell (
   input  wire logic       clk_in,
   input  wire logic       rst_n_in,
   input  wire logic       active_in,
   input  wire logic [7:0] phase_in,
   input  wire logic [7:0] level_in,
   output logic            on_out
);
   typedef struct packed {
      logic on;
   } ldpr_cell_st_s;

   ldpr_cell_st_s st;
   ldpr_cell_st_s next_st;

   always_comb begin
      next_st    = st;
      next_st.on = active_in && (phase_in < level_in); // see R14
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign on_out = st.on;

   a_zero_dark: assert property (@(posedge clk_in) disable iff (!rst_n_in) // see R14
      (level_in == 8'h00) |=> !on_out)
      else $error("dot with zero level was driven");
   a_on_cause: assert property (@(posedge clk_in) disable iff (!rst_n_in) // see R6
      on_out == $past(active_in && (phase_in < level_in)))
      else $error("column source does not follow phase and level");
endmodule

// file: hw/ldpr_dot_regs.sv
// Paged dot registers, fault flags, function bytes and the scanned column drive.
`timescale 1ns/1ps
// Operation
// R1: Open flags kept per dot, six per byte low bits, top two read zero.
// R2: Short flags kept per dot, six per byte, one means shorted, cleared at reset.
// R3: Short flag bytes sit at 30h to 47h of page zero, two per row.
// R4: Each dot has its own eight bit duty value resetting to zero.
// R5: Duty bytes sit on page one at addresses 00h through BDh.
// R6: Dot average current follows duty over 256, global current and row duty.
// R7: Slow rate: each row active 128 us then blanked 8 us.
// R8: Column current scaled by global current code at function address 01h.
// R9: Per dot mode selector in two low bits, resets to 00, upper bits ignored.
// R10: Mode selector bytes sit on page two at addresses 00h through BDh.
// R11: Mode 00 uses duty; 01, 10, 11 attach breathing profiles one to three.
// R12: Detect trigger rising zero to one starts a pass that refreshes flags.
// R13: Frequency select bit picks 7.4 kHz when clear, 25 kHz when set.
// R14: Column driven while phase is below duty; zero duty stays dark.
// R15: Host picks the page first; writes to fault flag bytes are ignored.
module ldpr_dot_regs #(
   parameter int unsigned ROWS = ldpr_pkg::ROWS,
   parameter int unsigned COLS = ldpr_pkg::COLS
) (
   input  wire logic                          CLK_SYS_IN,
   input  wire logic                          RST_B_IN,
   input  ldpr_pkg::ldpr_reg_req_s            REG_REQ_IN,
   output logic [7:0]                         REG_RDATA_OUT,
   output logic                               REG_RVALID_OUT,
   input  wire logic                          FAULT_DONE_IN,
   input  wire logic [ldpr_pkg::DOTS-1:0]     FAULT_OPEN_IN,
   input  wire logic [ldpr_pkg::DOTS-1:0]     FAULT_SHORT_IN,
   output logic                               DETECT_START_OUT,
   input  wire logic [2:0][7:0]               BREATH_LEVEL_IN,
   output logic [7:0]                         GLOBAL_CURRENT_OUT,
   output logic                               FREQ_FAST_OUT,
   output logic [ROWS-1:0]                    ROW_SWITCH_OUT,
   output logic [COLS-1:0]                    COLUMN_SOURCE_OUT
);
   if (ROWS != ldpr_pkg::ROWS || COLS != ldpr_pkg::COLS) begin : g_size_check
      $error("register map serves a 12 by 12 matrix only");
   end

   localparam int unsigned NB = ldpr_pkg::DOT_BYTES;
   localparam int unsigned ND = ldpr_pkg::DOTS;

   typedef struct packed {
      logic [NB-1:0][7:0] duty;
      logic [NB-1:0][1:0] mode;
      logic [ND-1:0]      open_flag;
      logic [ND-1:0]      short_flag;
      logic               freq;
      logic               detect;
      logic [7:0]         global_current_code;
      logic [7:0]         rdata;
      logic               rvalid;
      logic               start;
      logic [ROWS-1:0]    rows;
   } ldpr_regs_st_s;

   ldpr_regs_st_s           st;
   ldpr_regs_st_s           next_st;
   logic [1:0]              rst_sync;
   logic                    rst_n;
   ldpr_pkg::ldpr_scan_s    scan;
   logic [COLS-1:0][7:0]    level;
   logic [7:0]              idx;
   logic [7:0]              row_sel;
   int unsigned             flag_base;

   // Reset is released through two flops so every flop leaves reset on the same edge.
   always_ff @(posedge CLK_SYS_IN or negedge RST_B_IN) begin
      if (!RST_B_IN) begin
         rst_sync <= 2'b00;
      end else begin
         rst_sync <= {rst_sync[0], 1'b1};
      end
   end
   assign rst_n = rst_sync[1];

   ldpr_row_scan #(
      .ROWS (ROWS)
   ) u_scan (
      .clk_in   (CLK_SYS_IN),
      .rst_n_in (rst_n),
      .fast_in  (st.freq),
      .scan_out (scan)
   );

   // Per column level for the active row; breathing profiles replace the duty byte.
   always_comb begin
      level = '0;
      for (int c = 0; c < COLS; c++) begin
         unique case (ldpr_pkg::ldpr_mode_e'(st.mode[8'(scan.row * ldpr_pkg::ROW_STRIDE + c)])) // see R11
            ldpr_pkg::MODE_DUTY:          level[c] = st.duty[8'(scan.row * ldpr_pkg::ROW_STRIDE + c)];
            ldpr_pkg::MODE_PROFILE_ONE:   level[c] = BREATH_LEVEL_IN[0];
            ldpr_pkg::MODE_PROFILE_TWO:   level[c] = BREATH_LEVEL_IN[1];
            ldpr_pkg::MODE_PROFILE_THREE: level[c] = BREATH_LEVEL_IN[2];
         endcase
      end
   end

   for (genvar g = 0; g < COLS; g++) begin : g_col
      ldpr_column_cell u_cell (
         .clk_in    (CLK_SYS_IN),
         .rst_n_in  (rst_n),
         .active_in (scan.active),
         .phase_in  (scan.phase),
         .level_in  (level[g]),
         .on_out    (COLUMN_SOURCE_OUT[g])
      );
   end

   always_comb begin
      next_st        = st;
      next_st.rvalid = 1'b0;
      next_st.start  = 1'b0;
      next_st.rdata  = ldpr_pkg::RESET_BYTE;
      idx            = 8'h00;
      row_sel        = 8'h00;
      flag_base      = 0;
      next_st.rows   = '0;
      if (scan.active) begin
         next_st.rows[scan.row] = 1'b1; // see R7
      end
      // A finished detection pass replaces both flag arrays at once.
      if (FAULT_DONE_IN) begin
         next_st.open_flag  = FAULT_OPEN_IN;  // see R12
         next_st.short_flag = FAULT_SHORT_IN; // see R2
      end
      if (REG_REQ_IN.wr) begin
         unique case (REG_REQ_IN.page)
            ldpr_pkg::PAGE_DUTY: begin
               if (REG_REQ_IN.addr <= ldpr_pkg::DOT_LAST) begin
                  next_st.duty[REG_REQ_IN.addr] = REG_REQ_IN.wdata; // see R4 R5
               end
            end
            ldpr_pkg::PAGE_MODE: begin
               if (REG_REQ_IN.addr <= ldpr_pkg::DOT_LAST) begin
                  next_st.mode[REG_REQ_IN.addr] = REG_REQ_IN.wdata[1:0]; // see R9 R10
               end
            end
            ldpr_pkg::PAGE_FUNC: begin
               if (REG_REQ_IN.addr == ldpr_pkg::FUNC_CONFIG) begin
                  next_st.freq   = REG_REQ_IN.wdata[ldpr_pkg::CFG_FREQ_BIT]; // see R13
                  next_st.detect = REG_REQ_IN.wdata[ldpr_pkg::CFG_DETECT_BIT];
                  next_st.start  = REG_REQ_IN.wdata[ldpr_pkg::CFG_DETECT_BIT] && !st.detect; // see R12
               end else if (REG_REQ_IN.addr == ldpr_pkg::FUNC_GCC) begin
                  next_st.global_current_code = REG_REQ_IN.wdata; // see R8
               end
            end
            default: begin
               // Fault flag bytes are read only, so writes to page zero are dropped.
               next_st.global_current_code = st.global_current_code; // see R15
            end
         endcase
      end
      if (REG_REQ_IN.rd) begin
         next_st.rvalid = 1'b1;
         if (REG_REQ_IN.page == ldpr_pkg::PAGE_LED_CTRL) begin
            if (REG_REQ_IN.addr >= ldpr_pkg::OPEN_FIRST && REG_REQ_IN.addr <= ldpr_pkg::OPEN_LAST) begin
               idx       = REG_REQ_IN.addr - ldpr_pkg::OPEN_FIRST;
               row_sel   = {1'b0, idx[7:1]};
               flag_base = row_sel * COLS + idx[0] * ldpr_pkg::FLAGS_PER_BYTE;
               next_st.rdata = {2'b00, st.open_flag[flag_base +: ldpr_pkg::FLAGS_PER_BYTE]}; // see R1
            end else if (REG_REQ_IN.addr >= ldpr_pkg::SHORT_FIRST && REG_REQ_IN.addr <= ldpr_pkg::SHORT_LAST) begin
               idx       = REG_REQ_IN.addr - ldpr_pkg::SHORT_FIRST; // see R3
               row_sel   = {1'b0, idx[7:1]};
               flag_base = row_sel * COLS + idx[0] * ldpr_pkg::FLAGS_PER_BYTE;
               next_st.rdata = {2'b00, st.short_flag[flag_base +: ldpr_pkg::FLAGS_PER_BYTE]}; // see R2
            end
         end
      end
   end

   always_ff @(posedge CLK_SYS_IN or negedge rst_n) begin
      if (!rst_n) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign REG_RDATA_OUT      = st.rdata;
   assign REG_RVALID_OUT     = st.rvalid;
   assign DETECT_START_OUT   = st.start;
   assign GLOBAL_CURRENT_OUT = st.global_current_code;
   assign FREQ_FAST_OUT      = st.freq;
   assign ROW_SWITCH_OUT     = st.rows;

   a_detect_rise: assert property (@(posedge CLK_SYS_IN) disable iff (!rst_n) // see R12
      (REG_REQ_IN.wr && REG_REQ_IN.page == ldpr_pkg::PAGE_FUNC && REG_REQ_IN.addr == ldpr_pkg::FUNC_CONFIG
       && REG_REQ_IN.wdata[ldpr_pkg::CFG_DETECT_BIT] && !st.detect) |=> DETECT_START_OUT ##1 !DETECT_START_OUT)
      else $error("detect start missing or longer than one cycle");
   a_fault_load: assert property (@(posedge CLK_SYS_IN) disable iff (!rst_n) // see R2
      FAULT_DONE_IN |=> st.open_flag == $past(FAULT_OPEN_IN) && st.short_flag == $past(FAULT_SHORT_IN))
      else $error("fault flags not refreshed");
   a_flag_upper: assert property (@(posedge CLK_SYS_IN) disable iff (!rst_n) // see R1
      REG_REQ_IN.rd |=> REG_RVALID_OUT && REG_RDATA_OUT[7:6] == 2'b00)
      else $error("read answer missing or upper bits set");
   a_duty_store: assert property (@(posedge CLK_SYS_IN) disable iff (!rst_n) // see R5
      (REG_REQ_IN.wr && REG_REQ_IN.page == ldpr_pkg::PAGE_DUTY && REG_REQ_IN.addr <= ldpr_pkg::DOT_LAST)
      |=> st.duty[$past(REG_REQ_IN.addr)] == $past(REG_REQ_IN.wdata))
      else $error("duty byte not stored");
   a_mode_store: assert property (@(posedge CLK_SYS_IN) disable iff (!rst_n) // see R9
      (REG_REQ_IN.wr && REG_REQ_IN.page == ldpr_pkg::PAGE_MODE && REG_REQ_IN.addr <= ldpr_pkg::DOT_LAST)
      |=> st.mode[$past(REG_REQ_IN.addr)] == $past(REG_REQ_IN.wdata[1:0]))
      else $error("mode selector not stored from low bits");
   a_gcc_out: assert property (@(posedge CLK_SYS_IN) disable iff (!rst_n) // see R8
      (REG_REQ_IN.wr && REG_REQ_IN.page == ldpr_pkg::PAGE_FUNC && REG_REQ_IN.addr == ldpr_pkg::FUNC_GCC)
      |=> GLOBAL_CURRENT_OUT == $past(REG_REQ_IN.wdata))
      else $error("global current code not applied");
   a_page0_ro: assert property (@(posedge CLK_SYS_IN) disable iff (!rst_n) // see R15
      (REG_REQ_IN.wr && REG_REQ_IN.page == ldpr_pkg::PAGE_LED_CTRL && !FAULT_DONE_IN)
      |=> $stable(st.open_flag) && $stable(st.short_flag))
      else $error("write changed a fault flag");
   a_row_onehot: assert property (@(posedge CLK_SYS_IN) disable iff (!rst_n) // see R7
      $onehot0(ROW_SWITCH_OUT))
      else $error("more than one row switch active");
   c_detect: cover property (@(posedge CLK_SYS_IN) disable iff (!rst_n) DETECT_START_OUT ##[1:50] FAULT_DONE_IN);
   c_fast: cover property (@(posedge CLK_SYS_IN) disable iff (!rst_n) FREQ_FAST_OUT && |COLUMN_SOURCE_OUT);
   c_short_read: cover property (@(posedge CLK_SYS_IN) disable iff (!rst_n) REG_RVALID_OUT && REG_RDATA_OUT != 8'h00);
endmodule

// file: hw/ldpr_pkg.sv
// Shared constants and carrier types of the LED dot register and scan block.
package ldpr_pkg;
   localparam int unsigned CLK_HZ             = 40_000_000;
   localparam int unsigned CLK_MHZ            = CLK_HZ / 1_000_000;
   localparam int unsigned PWM_STEPS          = 256;
   localparam int unsigned ROW_ACTIVE_SLOW_US = 128;
   localparam int unsigned ROW_BLANK_SLOW_US  = 8;
   localparam int unsigned PWM_FAST_HZ        = 25_000;
   // Step and blank lengths in cycles; the fast step rounds down so the row period never exceeds its slot.
   localparam int unsigned STEP_SLOW_CYC      = (ROW_ACTIVE_SLOW_US * CLK_MHZ + PWM_STEPS - 1) / PWM_STEPS;
   localparam int unsigned BLANK_CYC          = ROW_BLANK_SLOW_US * CLK_MHZ;
   localparam int unsigned FAST_ROW_CYC       = CLK_HZ / PWM_FAST_HZ;
   localparam int unsigned STEP_FAST_CYC      = (FAST_ROW_CYC - BLANK_CYC) / PWM_STEPS;

   localparam int unsigned ROWS               = 12;
   localparam int unsigned COLS               = 12;
   localparam int unsigned DOTS               = ROWS * COLS;
   localparam int unsigned ROW_STRIDE         = 16;
   localparam int unsigned DOT_BYTES          = 190;
   localparam int unsigned FLAGS_PER_BYTE     = 6;

   localparam logic [7:0]  PAGE_LED_CTRL      = 8'h00;
   localparam logic [7:0]  PAGE_DUTY          = 8'h01;
   localparam logic [7:0]  PAGE_MODE          = 8'h02;
   localparam logic [7:0]  PAGE_FUNC          = 8'h03;
   localparam logic [7:0]  OPEN_FIRST         = 8'h18;
   localparam logic [7:0]  OPEN_LAST          = 8'h2f;
   localparam logic [7:0]  SHORT_FIRST        = 8'h30;
   localparam logic [7:0]  SHORT_LAST         = 8'h47;
   localparam logic [7:0]  DOT_FIRST          = 8'h00;
   localparam logic [7:0]  DOT_LAST           = 8'hbd;
   localparam logic [7:0]  FUNC_CONFIG        = 8'h00;
   localparam logic [7:0]  FUNC_GCC           = 8'h01;
   localparam int unsigned CFG_DETECT_BIT     = 2;
   localparam int unsigned CFG_FREQ_BIT       = 4;
   localparam logic [7:0]  RESET_BYTE         = 8'h00;

   typedef enum logic [1:0] {
      MODE_DUTY,
      MODE_PROFILE_ONE,
      MODE_PROFILE_TWO,
      MODE_PROFILE_THREE
   } ldpr_mode_e;

   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] page;
      logic [7:0] addr;
      logic [7:0] wdata;
   } ldpr_reg_req_s;

   typedef struct packed {
      logic       active;
      logic [3:0] row;
      logic [7:0] phase;
   } ldpr_scan_s;
endpackage

// file: hw/ldpr_row_scan.sv
// Row slot timer: PWM phase counter, active and blank intervals, row index.
`timescale 1ns/1ps
module ldpr_row_scan #(
   parameter int unsigned ROWS = ldpr_pkg::ROWS
) (
   input  wire logic               clk_in,
   input  wire logic               rst_n_in,
   input  wire logic               fast_in,
   output ldpr_pkg::ldpr_scan_s    scan_out
);
   if (ROWS < 1 || ROWS > 16) begin : g_rows_check
      $error("ROWS must be 1 to 16");
   end

   typedef struct packed {
      logic [10:0] cnt;
      logic        active;
      logic [3:0]  row;
      logic [7:0]  phase;
   } ldpr_scan_st_s;

   ldpr_scan_st_s st;
   ldpr_scan_st_s next_st;
   logic [10:0]   step_last;

   localparam logic [10:0] SLOW_LAST  = 11'(ldpr_pkg::STEP_SLOW_CYC - 1);
   localparam logic [10:0] FAST_LAST  = 11'(ldpr_pkg::STEP_FAST_CYC - 1);
   localparam logic [10:0] BLANK_LAST = 11'(ldpr_pkg::BLANK_CYC - 1);
   localparam logic [3:0]  ROW_LAST   = 4'(ROWS - 1);

   always_comb begin
      next_st   = st;
      step_last = fast_in ? FAST_LAST : SLOW_LAST; // see R13
      if (st.active) begin
         if (st.cnt >= step_last) begin
            next_st.cnt = 11'h000;
            if (st.phase == 8'hff) begin
               next_st.active = 1'b0; // see R7
               next_st.phase  = 8'h00;
            end else begin
               next_st.phase = st.phase + 8'h01;
            end
         end else begin
            next_st.cnt = st.cnt + 11'h001;
         end
      end else begin
         if (st.cnt == BLANK_LAST) begin
            next_st.cnt    = 11'h000;
            next_st.active = 1'b1;
            next_st.row    = (st.row == ROW_LAST) ? 4'h0 : st.row + 4'h1;
         end else begin
            next_st.cnt = st.cnt + 11'h001;
         end
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign scan_out = '{active: st.active, row: st.row, phase: st.phase};

   a_blank_ends: assert property (@(posedge clk_in) disable iff (!rst_n_in) // see R7
      (!st.active && st.cnt == BLANK_LAST) |=> st.active && st.phase == 8'h00)
      else $error("blank interval did not end after its length");
   a_phase_steps: assert property (@(posedge clk_in) disable iff (!rst_n_in) // see R13
      (st.active && $changed(st.phase)) |-> ($past(st.cnt) == $past(fast_in ? FAST_LAST : SLOW_LAST))
      || ($past(fast_in) != $past(fast_in, 2)))
      else $error("phase advanced off a step boundary");
   c_row_wrap: cover property (@(posedge clk_in) disable iff (!rst_n_in)
      $changed(st.row) && st.row == 4'h0);
endmodule

// file: verif/ldpr_fault_model.sv
// Behavioural fault detector that answers a detection start with one flag load; a start during a running pass restarts it.
`timescale 1ns/1ps
module ldpr_fault_model #(
   parameter logic [ldpr_pkg::DOTS-1:0] OPEN_PAT  = '0,
   parameter logic [ldpr_pkg::DOTS-1:0] SHORT_PAT = '0,
   parameter int unsigned               DELAY     = 16
) (
   input  wire logic                  clk_in,
   input  wire logic                  rst_n_in,
   input  wire logic                  start_in,
   output logic                       done_out,
   output logic [ldpr_pkg::DOTS-1:0]  open_out,
   output logic [ldpr_pkg::DOTS-1:0]  short_out
);
   int unsigned cnt;
   // A new start restarts the pass, so two starts close together give a single load.
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         cnt      <= 0;
         done_out <= 1'b0;
      end else begin
         done_out <= (cnt == 1);
         if (start_in) begin
            cnt <= DELAY;
         end else if (cnt != 0) begin
            cnt <= cnt - 1;
         end
      end
   end
   // Outside the load pulse the lines carry the inverse, so a load at the wrong edge shows up.
   assign open_out  = done_out ? OPEN_PAT : ~OPEN_PAT;
   assign short_out = done_out ? SHORT_PAT : ~SHORT_PAT;
endmodule

// file: verif/tb_top.sv
// Self-checking bench for the paged dot registers and the row scan.
`timescale 1ns/1ps
module tb_top;
   localparam logic [143:0] OPAT = {8{18'h2d1c9}};
   localparam logic [143:0] SPAT = {9{16'h7e35}};
   logic                    clk   = 1'b0;
   logic                    rst_b = 1'b0;
   ldpr_pkg::ldpr_reg_req_s req   = '0;
   logic [2:0][7:0]         bl    = {8'h63, 8'h42, 8'h21};
   logic [7:0]              rdata;
   logic [7:0]              gcur;
   logic                    rvalid;
   logic                    done;
   logic                    start;
   logic                    fast;
   logic [143:0]            fo;
   logic [143:0]            fs;
   logic [11:0]             rows;
   logic [11:0]             cols;
   logic [11:0]             row_a;
   logic [11:0]             row_b;
   int                      fail_count = 0;
   int                      samples_checked = 0;
   int                      len;
   int                      blk;
   int                      n;
   int                      on [12];
   logic [7:0] duty [12] = '{8'h00, 8'h01, 8'hff, 8'h80, 8'hff, 8'hff, 8'hff, 8'h40, 8'h00, 8'h00, 8'h00, 8'h00};
   logic [7:0] mode [12] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h02, 8'h03, 8'hfc, 8'h00, 8'h00, 8'h00, 8'h00};

   always #12.5 clk = ~clk;

   ldpr_dot_regs DUT (.CLK_SYS_IN(clk), .RST_B_IN(rst_b), .REG_REQ_IN(req), .REG_RDATA_OUT(rdata),
      .REG_RVALID_OUT(rvalid), .FAULT_DONE_IN(done), .FAULT_OPEN_IN(fo), .FAULT_SHORT_IN(fs),
      .DETECT_START_OUT(start), .BREATH_LEVEL_IN(bl), .GLOBAL_CURRENT_OUT(gcur), .FREQ_FAST_OUT(fast),
      .ROW_SWITCH_OUT(rows), .COLUMN_SOURCE_OUT(cols));
   ldpr_fault_model #(.OPEN_PAT(OPAT), .SHORT_PAT(SPAT), .DELAY(16)) u_fault (.clk_in(clk),
      .rst_n_in(rst_b), .start_in(start), .done_out(done), .open_out(fo), .short_out(fs));

   task automatic summarize;
      $display("checks=%0d mismatches=%0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   task automatic hang;
      fail_count++;
      summarize;
   endtask

   task automatic chkw(input logic [11:0] g, input logic [11:0] e);
      samples_checked++;
      if (g !== e) begin
         fail_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask

   task automatic chkn(input int g, input int e);
      samples_checked++;
      if (g != e) begin
         fail_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask

   task automatic wr(input logic [7:0] pg, input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      req = '{wr: 1'b1, rd: 1'b0, page: pg, addr: a, wdata: d};
      @(negedge clk);
      req = '0;
   endtask

   task automatic rdc(input logic [7:0] pg, input logic [7:0] a, input logic [7:0] e);
      @(negedge clk);
      req = '{wr: 1'b0, rd: 1'b1, page: pg, addr: a, wdata: 8'h00};
      @(negedge clk);
      req = '0;
      chkw({11'h000, rvalid}, 12'h001);
      chkw({4'h0, rdata}, {4'h0, e});
   endtask

   // Waits out any running slot, then measures one blank and the active slot behind it.
   task automatic slot(output int b, output int ln, output logic [11:0] rw);
      for (int c = 0; c < 12; c++) begin
         on[c] = 0;
      end
      b = 0;
      ln = 0;
      for (n = 0; rows !== 12'h000; n++) begin
         if (n > 12000) hang;
         @(negedge clk);
      end
      for (n = 0; rows === 12'h000; n++) begin
         if (n > 12000) hang;
         @(negedge clk);
         b++;
      end
      rw = rows;
      while (rows === rw && ln < 12000) begin
         for (int c = 0; c < 12; c++) begin
            on[c] += int'(cols[c]);
         end
         ln++;
         @(negedge clk);
      end
   endtask

   function automatic int lvl(input int c);
      return (mode[c][1:0] == 2'b00) ? int'(duty[c]) : int'(bl[int'(mode[c][1:0]) - 1]);
   endfunction

   task automatic wait_done;
      for (n = 0; done !== 1'b1; n++) begin
         if (n > 200) hang;
         @(negedge clk);
      end
      @(negedge clk);
   endtask

   initial begin
      repeat (4) @(negedge clk);
      rst_b = 1'b1;
      repeat (4) @(negedge clk);
      chkw({4'h0, gcur}, 12'h000);
      chkw({11'h000, fast}, 12'h000);
      rdc(ldpr_pkg::PAGE_LED_CTRL, ldpr_pkg::OPEN_FIRST, 8'h00);
      rdc(ldpr_pkg::PAGE_LED_CTRL, ldpr_pkg::SHORT_LAST, 8'h00);
      for (int c = 0; c < 12; c++) begin
         wr(ldpr_pkg::PAGE_DUTY, 8'h10 + 8'(c), duty[c]);
         wr(ldpr_pkg::PAGE_MODE, 8'h10 + 8'(c), mode[c]);
      end
      wr(ldpr_pkg::PAGE_DUTY, ldpr_pkg::DOT_FIRST, 8'hff);
      slot(blk, len, row_a);
      chkw(row_a, 12'h002);
      chkn(len, ldpr_pkg::ROW_ACTIVE_SLOW_US * ldpr_pkg::CLK_MHZ);
      for (int c = 0; c < 12; c++) begin
         chkn(on[c], lvl(c) * ldpr_pkg::STEP_SLOW_CYC);
      end
      slot(blk, len, row_b);
      chkn(blk, ldpr_pkg::ROW_BLANK_SLOW_US * ldpr_pkg::CLK_MHZ);
      chkw(row_b, 12'h004);
      wr(ldpr_pkg::PAGE_FUNC, ldpr_pkg::FUNC_GCC, 8'hb5);
      chkw({4'h0, gcur}, 12'h0b5);
      wr(ldpr_pkg::PAGE_FUNC, ldpr_pkg::FUNC_CONFIG, 8'h04);
      chkw({11'h000, start}, 12'h001);
      wr(ldpr_pkg::PAGE_FUNC, ldpr_pkg::FUNC_CONFIG, 8'h04);
      chkw({11'h000, start}, 12'h000);
      wait_done;
      for (int r = 0; r < 12; r++) begin
         rdc(ldpr_pkg::PAGE_LED_CTRL, ldpr_pkg::OPEN_FIRST + 8'(2 * r), {2'b00, OPAT[r * 12 +: 6]});
         rdc(ldpr_pkg::PAGE_LED_CTRL, ldpr_pkg::OPEN_FIRST + 8'(2 * r + 1), {2'b00, OPAT[r * 12 + 6 +: 6]});
         rdc(ldpr_pkg::PAGE_LED_CTRL, ldpr_pkg::SHORT_FIRST + 8'(2 * r), {2'b00, SPAT[r * 12 +: 6]});
         rdc(ldpr_pkg::PAGE_LED_CTRL, ldpr_pkg::SHORT_FIRST + 8'(2 * r + 1), {2'b00, SPAT[r * 12 + 6 +: 6]});
      end
      wr(ldpr_pkg::PAGE_LED_CTRL, ldpr_pkg::SHORT_FIRST, ~{2'b00, SPAT[5:0]});
      rdc(ldpr_pkg::PAGE_LED_CTRL, ldpr_pkg::SHORT_FIRST, {2'b00, SPAT[5:0]});
      rdc(ldpr_pkg::PAGE_LED_CTRL, 8'h17, 8'h00);
      rdc(ldpr_pkg::PAGE_LED_CTRL, 8'h48, 8'h00);
      rdc(ldpr_pkg::PAGE_DUTY, 8'h12, 8'h00);
      wr(ldpr_pkg::PAGE_FUNC, ldpr_pkg::FUNC_CONFIG, 8'h00);
      wr(ldpr_pkg::PAGE_FUNC, ldpr_pkg::FUNC_CONFIG, 8'h04);
      chkw({11'h000, start}, 12'h001);
      wait_done;
      // Row four gets the same dot pattern so the fast rate is checked per column as well.
      for (int c = 0; c < 12; c++) begin
         wr(ldpr_pkg::PAGE_DUTY, 8'h40 + 8'(c), duty[c]);
         wr(ldpr_pkg::PAGE_MODE, 8'h40 + 8'(c), mode[c]);
      end
      wr(ldpr_pkg::PAGE_FUNC, ldpr_pkg::FUNC_CONFIG, 8'h14);
      chkw({11'h000, start}, 12'h000);
      chkw({11'h000, fast}, 12'h001);
      slot(blk, len, row_a);
      slot(blk, len, row_b);
      for (int c = 0; c < 12; c++) begin
         chkn(on[c], lvl(c) * ldpr_pkg::STEP_FAST_CYC);
      end
      chkn(len, ldpr_pkg::PWM_STEPS * ldpr_pkg::STEP_FAST_CYC);
      chkn(blk, ldpr_pkg::BLANK_CYC);
      chkw(row_b, {row_a[10:0], row_a[11]});
      summarize;
   end
endmodule
